/* design/aqra_pkg.sv */
// Constants and types for the AXI4 QoS and region aware master.
// How it works
// - Every address carries its four-bit QoS value.
// - Larger QoS value means more urgent transaction.
// - QoS zero means no QoS participation.
// - QoS disabled: drive zero on both channels.
// - Programmable QoS value per traffic stream.
// - Every address carries a four-bit region value.
// - Region constant within aligned 4-kilobyte space.
// - Single decode range: drive default region.
// - Region produced only after address decode.
// - Address and data valid independent of ready.
package aqra_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int ID_W = 4;
  localparam int QOS_W = 4;
  localparam int REGION_W = 4;
  localparam int STREAM_W = 2;
  localparam int STREAMS = 4;
  localparam int REGION_LSB = 28;
  localparam logic [QOS_W-1:0] QOS_NONE = 4'h0;
  localparam logic [REGION_W-1:0] REGION_DEFAULT = 4'h0;
  localparam logic [7:0] LEN_SINGLE = 8'h00;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;

  typedef enum logic [4:0] {
    AQRA_IDLE  = 5'h01,
    AQRA_WRITE = 5'h02,
    AQRA_WRESP = 5'h04,
    AQRA_READ  = 5'h08,
    AQRA_RDATA = 5'h10
  } aqra_state_t;
endpackage

/* design/aqra_attr_if.sv */
// Link between the master and its QoS and region source.
`timescale 1ns/1ps
interface aqra_attr_if;
  import aqra_pkg::*;
  logic [STREAM_W-1:0] stream;
  logic [ADDR_W-1:0] addr;
  logic [QOS_W-1:0] qos;
  logic [REGION_W-1:0] region;

  modport src
  (
    input stream,
    input addr,
    output qos,
    output region
  );
  modport user
  (
    output stream,
    output addr,
    input qos,
    input region
  );
endinterface

/* design/aqra_attr_src.sv */
// Per-stream QoS table and region decode for outgoing addresses.
`timescale 1ns/1ps
module aqra_attr_src
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cfg_qos_en,
  input wire logic cfg_multi_region,
  input wire logic cfg_qos_we,
  input wire logic [aqra_pkg::STREAM_W-1:0] cfg_qos_stream,
  input wire logic [aqra_pkg::QOS_W-1:0] cfg_qos_value,
  aqra_attr_if.src attr
);
  import aqra_pkg::*;

  logic [QOS_W-1:0] qos_tab_q [STREAMS];
  logic [QOS_W-1:0] qos_tab_d [STREAMS];

  always_comb
  begin
    qos_tab_d = qos_tab_q;
    if (cfg_qos_we)
    begin
      qos_tab_d[cfg_qos_stream] = cfg_qos_value;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < STREAMS; i++)
      begin
        qos_tab_q[i] <= QOS_NONE;
      end
    end
    else
    begin
      qos_tab_q <= qos_tab_d;
    end
  end

  always_comb
  begin
    attr.qos = cfg_qos_en ? qos_tab_q[attr.stream] : QOS_NONE;
    attr.region = cfg_multi_region ? attr.addr[REGION_LSB +: REGION_W] : REGION_DEFAULT;
  end
endmodule // aqra_attr_src

/* design/aqra_master.sv */
// AXI4 master issuing single-beat reads and writes with QoS and region.
`timescale 1ns/1ps
module aqra_master
(
  input wire logic sys_clk,
  input wire logic reset_n,
  // User command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [aqra_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [aqra_pkg::ID_W-1:0] cmd_id,
  input wire logic [aqra_pkg::DATA_W-1:0] cmd_data,
  input wire logic [aqra_pkg::STREAM_W-1:0] cmd_stream,
  output logic rsp_valid,
  output logic rsp_write,
  output logic [aqra_pkg::ID_W-1:0] rsp_id,
  output logic [1:0] rsp_resp,
  output logic [aqra_pkg::DATA_W-1:0] rsp_data,
  // Configuration
  input wire logic cfg_qos_en,
  input wire logic cfg_multi_region,
  input wire logic cfg_qos_we,
  input wire logic [aqra_pkg::STREAM_W-1:0] cfg_qos_stream,
  input wire logic [aqra_pkg::QOS_W-1:0] cfg_qos_value,
  // Write address channel
  output logic awvalid,
  input wire logic awready,
  output logic [aqra_pkg::ID_W-1:0] awid,
  output logic [aqra_pkg::ADDR_W-1:0] awaddr,
  output logic [7:0] awlen,
  output logic [2:0] awsize,
  output logic [1:0] awburst,
  output logic [aqra_pkg::QOS_W-1:0] awqos,
  output logic [aqra_pkg::REGION_W-1:0] awregion,
  // Write data channel
  output logic wvalid,
  input wire logic wready,
  output logic [aqra_pkg::DATA_W-1:0] wdata,
  output logic [aqra_pkg::DATA_W/8-1:0] wstrb,
  output logic wlast,
  // Write response channel
  input wire logic bvalid,
  output logic bready,
  input wire logic [aqra_pkg::ID_W-1:0] bid,
  input wire logic [1:0] bresp,
  // Read address channel
  output logic arvalid,
  input wire logic arready,
  output logic [aqra_pkg::ID_W-1:0] arid,
  output logic [aqra_pkg::ADDR_W-1:0] araddr,
  output logic [7:0] arlen,
  output logic [2:0] arsize,
  output logic [1:0] arburst,
  output logic [aqra_pkg::QOS_W-1:0] arqos,
  output logic [aqra_pkg::REGION_W-1:0] arregion,
  // Read data channel
  input wire logic rvalid,
  output logic rready,
  input wire logic [aqra_pkg::ID_W-1:0] rid,
  input wire logic [aqra_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rlast
);
  import aqra_pkg::*;

  aqra_attr_if attr ();

  aqra_state_t state_q, state_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [ID_W-1:0] id_q, id_d;
  logic [DATA_W-1:0] data_q, data_d;
  logic [QOS_W-1:0] qos_q, qos_d;
  logic [REGION_W-1:0] region_q, region_d;
  logic aw_pend_q, aw_pend_d;
  logic w_pend_q, w_pend_d;
  logic ar_pend_q, ar_pend_d;
  logic rsp_valid_q, rsp_valid_d;
  logic rsp_write_q, rsp_write_d;
  logic [ID_W-1:0] rsp_id_q, rsp_id_d;
  logic [1:0] rsp_resp_q, rsp_resp_d;
  logic [DATA_W-1:0] rsp_data_q, rsp_data_d;

  // Region comes from this master's own decode
  aqra_attr_src u_attr
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cfg_qos_en(cfg_qos_en),
    .cfg_multi_region(cfg_multi_region),
    .cfg_qos_we(cfg_qos_we),
    .cfg_qos_stream(cfg_qos_stream),
    .cfg_qos_value(cfg_qos_value),
    .attr(attr.src)
  );

  assign attr.stream = cmd_stream;
  assign attr.addr = cmd_addr;

  // Handshake outputs
  assign cmd_ready = (state_q == AQRA_IDLE);
  // Ready only once response is seen
  assign bready = (state_q == AQRA_WRESP) && bvalid;
  assign rready = (state_q == AQRA_RDATA) && rvalid;

  always_comb
  begin
    state_d = state_q;
    addr_d = addr_q;
    id_d = id_q;
    data_d = data_q;
    qos_d = qos_q;
    region_d = region_q;
    aw_pend_d = aw_pend_q;
    w_pend_d = w_pend_q;
    ar_pend_d = ar_pend_q;
    rsp_valid_d = 1'b0;
    rsp_write_d = rsp_write_q;
    rsp_id_d = rsp_id_q;
    rsp_resp_d = rsp_resp_q;
    rsp_data_d = rsp_data_q;
    case (state_q)
      AQRA_IDLE:
      begin
        if (cmd_valid)
        begin
          addr_d = cmd_addr;
          id_d = cmd_id;
          data_d = cmd_data;
          qos_d = attr.qos;
          region_d = attr.region;
          if (cmd_write)
          begin
            aw_pend_d = 1'b1;
            w_pend_d = 1'b1;
            state_d = AQRA_WRITE;
          end
          else
          begin
            ar_pend_d = 1'b1;
            state_d = AQRA_READ;
          end
        end
      end
      AQRA_WRITE:
      begin
        // Each valid drops only on its own handshake
        if (awready)
        begin
          aw_pend_d = 1'b0;
        end
        if (wready)
        begin
          w_pend_d = 1'b0;
        end
        if (!aw_pend_d && !w_pend_d)
        begin
          state_d = AQRA_WRESP;
        end
      end
      AQRA_WRESP:
      begin
        if (bvalid)
        begin
          rsp_valid_d = 1'b1;
          rsp_write_d = 1'b1;
          rsp_id_d = bid;
          rsp_resp_d = bresp;
          rsp_data_d = '0;
          state_d = AQRA_IDLE;
        end
      end
      AQRA_READ:
      begin
        if (arready)
        begin
          ar_pend_d = 1'b0;
          state_d = AQRA_RDATA;
        end
      end
      AQRA_RDATA:
      begin
        if (rvalid && rlast)
        begin
          rsp_valid_d = 1'b1;
          rsp_write_d = 1'b0;
          rsp_id_d = rid;
          rsp_resp_d = rresp;
          rsp_data_d = rdata;
          state_d = AQRA_IDLE;
        end
      end
      default:
      begin
        aw_pend_d = 1'b0;
        w_pend_d = 1'b0;
        ar_pend_d = 1'b0;
        state_d = AQRA_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= AQRA_IDLE;
      addr_q <= '0;
      id_q <= '0;
      data_q <= '0;
      qos_q <= QOS_NONE;
      region_q <= REGION_DEFAULT;
      aw_pend_q <= 1'b0;
      w_pend_q <= 1'b0;
      ar_pend_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_write_q <= 1'b0;
      rsp_id_q <= '0;
      rsp_resp_q <= RESP_OKAY;
      rsp_data_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      addr_q <= addr_d;
      id_q <= id_d;
      data_q <= data_d;
      qos_q <= qos_d;
      region_q <= region_d;
      aw_pend_q <= aw_pend_d;
      w_pend_q <= w_pend_d;
      ar_pend_q <= ar_pend_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_write_q <= rsp_write_d;
      rsp_id_q <= rsp_id_d;
      rsp_resp_q <= rsp_resp_d;
      rsp_data_q <= rsp_data_d;
    end
  end

  // Address and write data channels, one transaction in flight
  assign awvalid = aw_pend_q;
  assign awid = id_q;
  assign awaddr = addr_q;
  assign awlen = LEN_SINGLE;
  assign awsize = SIZE_WORD;
  assign awburst = BURST_INCR;
  assign awqos = qos_q;
  assign awregion = region_q;
  assign wvalid = w_pend_q;
  assign wdata = data_q;
  assign wstrb = '1;
  assign wlast = 1'b1;
  assign arvalid = ar_pend_q;
  assign arid = id_q;
  assign araddr = addr_q;
  assign arlen = LEN_SINGLE;
  assign arsize = SIZE_WORD;
  assign arburst = BURST_INCR;
  assign arqos = qos_q;
  assign arregion = region_q;

  assign rsp_valid = rsp_valid_q;
  assign rsp_write = rsp_write_q;
  assign rsp_id = rsp_id_q;
  assign rsp_resp = rsp_resp_q;
  assign rsp_data = rsp_data_q;
endmodule // aqra_master

/* testbench/aqra_master_checker.sv */
// Port assertions for the AXI4 QoS and region master.
`timescale 1ns/1ps
module aqra_master_checker
(
  input wire logic sys_clk, reset_n, cfg_qos_en, cfg_multi_region,
  input wire logic awvalid, awready, wvalid, wready, arvalid, arready,
  input wire logic bvalid, bready, rvalid, rready, wlast,
  input wire logic [31:0] awaddr, araddr, wdata,
  input wire logic [7:0] awlen, arlen,
  input wire logic [1:0] awburst, arburst,
  input wire logic [3:0] awqos, awregion, arqos, arregion, wstrb
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_AW_HOLD: assert property (awvalid && !awready |=>
    awvalid && $stable(awaddr) && $stable(awqos) && $stable(awregion))
    else $error("awvalid or its payload moved before handshake");
  AST_W_HOLD: assert property (wvalid && !wready |=> wvalid && $stable(wdata))
    else $error("wvalid or wdata moved before handshake");
  AST_AR_HOLD: assert property (arvalid && !arready |=>
    arvalid && $stable(araddr) && $stable(arqos) && $stable(arregion))
    else $error("arvalid or its payload moved before handshake");
  AST_AW_W_TOGETHER: assert property ($rose(awvalid) |-> $rose(wvalid))
    else $error("awvalid raised without wvalid");
  AST_AWQOS_OFF: assert property (awvalid && !cfg_qos_en |-> awqos == 4'h0)
    else $error("awqos not zero with qos disabled");
  AST_ARQOS_OFF: assert property (arvalid && !cfg_qos_en |-> arqos == 4'h0)
    else $error("arqos not zero with qos disabled");
  AST_AWREGION: assert property (awvalid |->
    awregion == (cfg_multi_region ? awaddr[31:28] : 4'h0))
    else $error("awregion disagrees with address");
  AST_ARREGION: assert property (arvalid |->
    arregion == (cfg_multi_region ? araddr[31:28] : 4'h0))
    else $error("arregion disagrees with address");
  AST_BREADY: assert property (bready |-> bvalid)
    else $error("bready without bvalid");
  AST_RREADY: assert property (rready |-> rvalid)
    else $error("rready without rvalid");
  AST_W_LAST: assert property (wvalid |-> wlast && wstrb == 4'hf)
    else $error("single write beat not marked last with all strobes");
  AST_AW_ONE: assert property (awvalid |-> awlen == 8'h0 && awburst == 2'h1)
    else $error("write address not a single incrementing beat");
  AST_AR_ONE: assert property (arvalid |-> arlen == 8'h0 && arburst == 2'h1)
    else $error("read address not a single incrementing beat");
  cover property (awvalid && awready && !wready);
  cover property (wvalid && wready && !awready);
  cover property (arvalid && arready);
endmodule // aqra_master_checker
bind aqra_master aqra_master_checker u_aqra_master_checker (.*);

/* testbench/aqra_slave_model.sv */
// Behavioural AXI4 slave facing the master.
`timescale 1ns/1ps
module aqra_slave_model #(parameter int NREG = 8)
(
  input wire logic sys_clk, reset_n,
  input wire logic [3:0] lat, wlat,
  input wire logic awvalid, wvalid, wlast, arvalid, bready, rready,
  input wire logic [31:0] awaddr, araddr, wdata,
  input wire logic [3:0] awid, arid, awqos, arqos, awregion, arregion,
  output logic awready, wready, arready, bvalid, rvalid, rlast,
  output logic [3:0] bid, rid,
  output logic [1:0] bresp, rresp,
  output logic [31:0] rdata, seen_wd, seen_a,
  output logic [11:0] seen_aw, seen_ar
);
  logic [3:0] cnt, bid_q, rid_q;
  logic [1:0] bresp_q, rresp_q;
  logic aw_ok, w_ok;
  logic [31:0] rd_q;
  // Idle response fields show the inverse of the last value
  assign rdata = rvalid ? rd_q : ~rd_q;
  assign rid = rvalid ? rid_q : ~rid_q;
  assign rresp = rvalid ? rresp_q : ~rresp_q;
  assign bid = bvalid ? bid_q : ~bid_q;
  assign bresp = bvalid ? bresp_q : ~bresp_q;
  assign rlast = rvalid;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {awready, wready, arready, bvalid, rvalid, aw_ok, w_ok, cnt} <= '0;
      {bid_q, rid_q, bresp_q, rresp_q, rd_q, seen_aw, seen_ar, seen_wd, seen_a} <= '0;
    end
    else
    begin
      cnt <= (awvalid || wvalid || arvalid) ? cnt + 4'h1 : 4'h0;
      awready <= awvalid && !awready && cnt >= lat;
      wready <= wvalid && !wready && cnt >= wlat;
      arready <= arvalid && !arready && cnt >= lat;
      if (awvalid && awready)
      begin
        aw_ok <= 1'b1;
        bid_q <= awid;
        bresp_q <= (awregion >= NREG) ? 2'h2 : 2'h0;
        seen_aw <= {awqos, awregion, awid};
        seen_a <= awaddr;
      end
      if (wvalid && wready && wlast)
      begin
        w_ok <= 1'b1;
        seen_wd <= wdata;
      end
      if (aw_ok && w_ok)
      begin
        bvalid <= 1'b1;
        aw_ok <= 1'b0;
        w_ok <= 1'b0;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rid_q <= arid;
        rd_q <= ~araddr;
        rresp_q <= (arregion >= NREG) ? 2'h2 : 2'h0;
        seen_ar <= {arqos, arregion, arid};
        seen_a <= araddr;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end
endmodule // aqra_slave_model

/* testbench/test_aqra_master.sv */
// Self-checking bench for the AXI4 QoS and region master.
`timescale 1ns/1ps
module test_aqra_master;
  localparam int NREG = 8;
  logic sys_clk, reset_n, cmd_valid, cmd_ready, cmd_write, rsp_valid, rsp_write;
  logic cfg_qos_en, cfg_multi_region, cfg_qos_we, awvalid, awready, wvalid, wready, wlast;
  logic bvalid, bready, arvalid, arready, rvalid, rready, rlast;
  logic [31:0] cmd_addr, cmd_data, rsp_data, awaddr, wdata, araddr, rdata;
  logic [3:0] cmd_id, rsp_id, cfg_qos_value, awid, awqos, awregion, wstrb, bid;
  logic [3:0] arid, arqos, arregion, rid, lat, wlat;
  logic [1:0] cmd_stream, cfg_qos_stream, rsp_resp, bresp, rresp, awburst, arburst;
  logic [7:0] awlen, arlen;
  logic [2:0] awsize, arsize;
  logic [11:0] seen_aw, seen_ar;
  logic [31:0] seen_wd, seen_a;
  int error_cnt;
  int comparisons;
  aqra_master u_aqra_master (.*);
  aqra_slave_model #(.NREG(NREG)) u_aqra_slave_model (.*);
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic set_qos(input logic [1:0] st, input logic [3:0] v);
    @(posedge sys_clk);
    #1 cfg_qos_we = 1'b1;
    cfg_qos_stream = st;
    cfg_qos_value = v;
    @(posedge sys_clk);
    #1 cfg_qos_we = 1'b0;
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [3:0] id,
    input logic [1:0] st, input logic [3:0] q, input logic [3:0] rg);
    int n;
    @(posedge sys_clk);
    #1 cmd_valid = 1'b1;
    {cmd_write, cmd_addr, cmd_id, cmd_data, cmd_stream} = {wr, a, id, ~a, st};
    chk("cmd_ready", 1, cmd_ready);
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    chk("cmd_busy", 0, cmd_ready);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("rsp_valid", 1, rsp_valid);
    chk("rsp_write", wr, rsp_write);
    chk("rsp_id", id, rsp_id);
    chk("rsp_resp", (rg >= NREG) ? 2'h2 : 2'h0, rsp_resp);
    chk("rsp_data", wr ? 32'h0 : ~a, rsp_data);
    chk("attr", {q, rg, id}, wr ? seen_aw : seen_ar);
    chk("addr", a, seen_a);
    if (wr)
      chk("wdata", ~a, seen_wd);
    @(posedge sys_clk);
    #1 chk("rsp_pulse", 0, rsp_valid);
  endtask
  task automatic t_qos_off;
    cfg_qos_en = 1'b0;
    set_qos(2'h1, 4'h9);
    xfer(1'b1, 32'h1000_0010, 4'h1, 2'h1, 4'h0, 4'h0);
    xfer(1'b0, 32'h1000_0014, 4'h2, 2'h1, 4'h0, 4'h0);
  endtask
  task automatic t_qos_streams;
    cfg_qos_en = 1'b1;
    for (int i = 0; i < 4; i++)
      set_qos(2'(i), 4'hf - 4'(i * 5));
    for (int i = 0; i < 8; i++)
      xfer(1'(i), 32'h2000_0100 + 32'(i * 4), 4'(i), 2'(i / 2), 4'hf - 4'((i / 2) * 5), 4'h0);
  endtask
  task automatic t_region;
    cfg_multi_region = 1'b1;
    xfer(1'b1, 32'h3000_0ffc, 4'h3, 2'h0, 4'hf, 4'h3);
    xfer(1'b0, 32'h3000_0000, 4'h3, 2'h0, 4'hf, 4'h3);
    xfer(1'b1, 32'hc000_0004, 4'h4, 2'h0, 4'hf, 4'hc);
    xfer(1'b0, 32'hf000_0000, 4'h5, 2'h3, 4'h0, 4'hf);
    cfg_multi_region = 1'b0;
    xfer(1'b0, 32'hc000_0004, 4'h6, 2'h0, 4'hf, 4'h0);
  endtask
  task automatic t_handshake;
    lat = 4'h3;
    xfer(1'b1, 32'h0000_0040, 4'h7, 2'h0, 4'hf, 4'h0);
    lat = 4'h0;
    wlat = 4'h4;
    xfer(1'b1, 32'h0000_0044, 4'h8, 2'h0, 4'hf, 4'h0);
    lat = 4'h5;
    xfer(1'b0, 32'h0000_0048, 4'h9, 2'h0, 4'hf, 4'h0);
  endtask
  task automatic t_reset;
    @(posedge sys_clk);
    #1 reset_n = 1'b0;
    chk("reset_cmd_ready", 1, cmd_ready);
    chk("reset_awvalid", 0, awvalid);
    @(posedge sys_clk);
    #1 reset_n = 1'b1;
    xfer(1'b1, 32'h0000_0050, 4'ha, 2'h0, 4'h0, 4'h0);
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    {sys_clk, reset_n, cmd_valid, cmd_write, cfg_qos_en, cfg_multi_region, cfg_qos_we} = '0;
    {cmd_addr, cmd_data, cmd_id, cmd_stream, cfg_qos_stream, cfg_qos_value, lat, wlat} = '0;
    error_cnt = 0;
    comparisons = 0;
    repeat (6) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    t_qos_off;
    t_qos_streams;
    t_region;
    t_handshake;
    t_reset;
    give_verdict;
  end
  initial
  begin
    #20000;
    error_cnt++;
    give_verdict;
  end
endmodule // test_aqra_master
